// *** lock_ctrl_defs.svh ***
// Constants for the locked sequence and override control block
`ifndef LOCK_CTRL_DEFS_SVH
`define LOCK_CTRL_DEFS_SVH
`define CNT_W 3
`define CNT_MAX 3'h4
`define CNT_ZERO 3'h0
`define CNT_ONE 3'h1
`define OFFS_W 14
`define PAGE_W 10
`define SEG_W 8
`define ADDR_W 24
`define PRIO_W 4
`define VEC_W 8
`define SAVE_CYC 2'h2
`define RESTORE_CYC 2'h2
`endif

// *** lock_ctrl_pkg.sv ***
// Types for the locked sequence and override control block
package lock_ctrl_pkg;
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_LOCK = 3'h1,
    OP_PAGE = 3'h2,
    OP_SEG = 3'h3,
    OP_EXTENDED_SFR_SPACE = 3'h4,
    OP_PAGE_EXTENDED_SFR_SPACE = 3'h5,
    OP_SEG_EXTENDED_SFR_SPACE = 3'h6
  } ext_op_t;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SAVE = 2'b01,
    ST_BRANCH = 2'b11,
    ST_RESTORE = 2'b10
  } entry_state_t;
endpackage

// *** ext_if.sv ***
// Extension state carried from the counter unit to the top module
`timescale 1ns/1ps
`include "lock_ctrl_defs.svh"
interface ext_if;
  logic active;
  logic page_ovr;
  logic seg_ovr;
  logic extended_sfr_space;
  logic [`PAGE_W-1:0] page;
  logic [`SEG_W-1:0] seg;
  modport unit (output active, page_ovr, seg_ovr, extended_sfr_space, page, seg);
  modport user (input active, page_ovr, seg_ovr, extended_sfr_space, page, seg);
endinterface

// *** ext_counter.sv ***
// Extension counter and override state for locked runs
`timescale 1ns/1ps
`include "lock_ctrl_defs.svh"
module ext_counter
  import lock_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire lock_ctrl_pkg::ext_op_t op,
  input wire logic op_valid,
  input wire logic [`CNT_W-1:0] op_count,
  input wire logic [`PAGE_W-1:0] op_page,
  input wire logic [`SEG_W-1:0] op_seg,
  input wire logic retire,
  input wire logic blocked,
  input wire logic break_run,
  ext_if.unit ext
);
  import lock_ctrl_pkg::*;
  logic [`CNT_W-1:0] count;
  logic load;
  logic [`CNT_W-1:0] load_val;
  // Operand count clipped to one to four
  assign load_val = (op_count == `CNT_ZERO) ? `CNT_ONE :
                    (op_count > `CNT_MAX) ? `CNT_MAX : op_count;
  // no effect while class B pending
  assign load = op_valid && (op != OP_NONE) && !blocked;
  assign ext.active = (count != `CNT_ZERO);
  // ---------------------------------------------
  // Counter
  // ---------------------------------------------
  // load counter; reload when nested
  always_ff @(posedge clk) begin
    if (rst || break_run) begin
      count <= `CNT_ZERO;
    end else if (load) begin
      count <= load_val;
    end else if (retire && count != `CNT_ZERO) begin
      count <= count - `CNT_ONE;
    end
  end
  // Mode flags follow the most recent loading instruction
  always_ff @(posedge clk) begin
    if (rst || break_run) begin
      ext.page_ovr <= 1'b0;
      ext.seg_ovr <= 1'b0;
      ext.extended_sfr_space <= 1'b0;
      ext.page <= '0;
      ext.seg <= '0;
    end else if (load) begin
      ext.page_ovr <= (op == OP_PAGE) || (op == OP_PAGE_EXTENDED_SFR_SPACE);
      ext.seg_ovr <= (op == OP_SEG) || (op == OP_SEG_EXTENDED_SFR_SPACE);
      ext.extended_sfr_space <= (op == OP_EXTENDED_SFR_SPACE) || (op == OP_PAGE_EXTENDED_SFR_SPACE) || (op == OP_SEG_EXTENDED_SFR_SPACE);
      ext.page <= op_page;
      ext.seg <= op_seg;
    end else if (retire && count == `CNT_ONE) begin
      ext.page_ovr <= 1'b0;
      ext.seg_ovr <= 1'b0;
      ext.extended_sfr_space <= 1'b0;
    end
  end
  count_step_a: assert property (@(posedge clk) disable iff (rst)
    (!retire && !load && !break_run) |=> count == $past(count))
    else $error("counter moved without retire");
  reload_val_a: assert property (@(posedge clk) disable iff (rst)
    (load && !break_run) |=> count == $past(load_val))
    else $error("counter not reloaded");
endmodule // ext_counter

// *** lock_ctrl.sv ***
// Locked sequence, address override and trap/interrupt entry control
`timescale 1ns/1ps
`include "lock_ctrl_defs.svh"
// Behaviour
// - Lock instruction locks next one to four instructions, count from operand.
// - Locked run blocks interrupts, event transfers and class A traps.
// - Class B traps still taken mid-run and end the run.
// - Inhibit acts at once; nothing serviced before the next instruction.
// - Multi-cycle instructions count once when retired.
// - Any opcode allowed inside a locked run.
// - Lock does nothing while a class B trap flag is set.
// - Normal data address is page pointer plus 14-bit offset.
// - Page override replaces page for run, pointers untouched.
// - Segment override uses 16-bit offset in the given segment.
// - Page and segment overrides inhibit like lock.
// - Overrides do nothing while a class B trap flag is set.
// - Register redirect sends short addressing to extended space.
// - Combined forms apply address override and redirect together.
// - Redirect forms inhibit like lock.
// - Each such instruction loads the extension counter.
// - Nested instruction reloads counter with its own count.
// - Idle inside a locked run blocks event transfers.
// - Interrupts need higher priority; traps taken regardless.
// - Entry saves state on stack then branches to vector.
// - Return restores state and resumes at interrupted point.
module lock_ctrl
  import lock_ctrl_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire lock_ctrl_pkg::ext_op_t EXT_OP,
  input wire logic EXT_VALID,
  input wire logic [`CNT_W-1:0] EXT_COUNT,
  input wire logic [`PAGE_W-1:0] EXT_PAGE,
  input wire logic [`SEG_W-1:0] EXT_SEG,
  input wire logic INSTR_RETIRE,
  input wire logic IDLE_ACTIVE,
  input wire logic RETURN_INSTR,
  input wire logic [1:0] DPP_SEL,
  input wire logic [4*`PAGE_W-1:0] DPP_PAGES,
  input wire logic [15:0] OPER_ADDR,
  input wire logic SHORT_ACCESS,
  input wire logic CLASS_B_PENDING,
  input wire logic CLASS_B_REQ,
  input wire logic [`VEC_W-1:0] CLASS_B_VEC,
  input wire logic CLASS_A_REQ,
  input wire logic [`VEC_W-1:0] CLASS_A_VEC,
  input wire logic IRQ_REQ,
  input wire logic [`PRIO_W-1:0] IRQ_PRIO,
  input wire logic [`VEC_W-1:0] IRQ_VEC,
  input wire logic PET_REQ,
  input wire logic [`PRIO_W-1:0] CPU_PRIO,
  output logic [`ADDR_W-1:0] DATA_ADDR,
  output logic SHORT_TO_EXTENDED_SFR_SPACE,
  output logic LOCKED,
  output logic PET_GRANT,
  output logic TRAP_B_ACK,
  output logic TRAP_A_ACK,
  output logic IRQ_ACK,
  output logic STATE_PUSH,
  output logic STATE_POP,
  output logic VEC_BRANCH,
  output logic [`VEC_W-1:0] VEC_NUM,
  output logic RESUME,
  output logic HOLD_FETCH
);
  import lock_ctrl_pkg::*;
  ext_if ext ();
  entry_state_t state;
  logic [1:0] cyc;
  logic inhibit;
  logic take_b;
  logic take_a;
  logic take_irq;
  logic loading;
  logic [`PAGE_W-1:0] page_sel;
  logic [`ADDR_W-1:0] next_addr;
  // ---------------------------------------------
  // Extension counter
  // ---------------------------------------------
  // retire pulse once per instruction
  ext_counter u_cnt (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .op(EXT_OP),
    .op_valid(EXT_VALID),
    .op_count(EXT_COUNT),
    .op_page(EXT_PAGE),
    .op_seg(EXT_SEG),
    .retire(INSTR_RETIRE),
    .blocked(CLASS_B_PENDING),
    .break_run(take_b),
    .ext(ext)
  );
  // ---------------------------------------------
  // Service gating
  // ---------------------------------------------
  // lock decode itself inhibits at once
  assign loading = EXT_VALID && (EXT_OP != OP_NONE) && !CLASS_B_PENDING;
  assign inhibit = ext.active || loading;
  assign take_b = (state == ST_RUN) && CLASS_B_REQ;
  // class A held off in a run
  assign take_a = (state == ST_RUN) && CLASS_A_REQ && !CLASS_B_REQ && !inhibit;
  // held requests retried once counter empties
  assign take_irq = (state == ST_RUN) && IRQ_REQ && (IRQ_PRIO > CPU_PRIO) &&
                    !CLASS_B_REQ && !CLASS_A_REQ && !inhibit;
  // also during idle in a run
  assign PET_GRANT = (state == ST_RUN) && PET_REQ && !inhibit && !CLASS_B_REQ &&
                     !CLASS_A_REQ && !take_irq;
  assign TRAP_B_ACK = take_b;
  assign TRAP_A_ACK = take_a;
  assign IRQ_ACK = take_irq;
  assign LOCKED = ext.active;
  assign HOLD_FETCH = (state != ST_RUN);
  // ---------------------------------------------
  // Entry and exit sequencer
  // ---------------------------------------------
  // save then branch; restore then resume
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      state <= ST_RUN;
      cyc <= 2'h0;
      VEC_NUM <= '0;
    end else begin
      unique case (state)
        ST_RUN: begin
          cyc <= 2'h0;
          if (take_b || take_a || take_irq) begin
            state <= ST_SAVE;
            VEC_NUM <= take_b ? CLASS_B_VEC : take_a ? CLASS_A_VEC : IRQ_VEC;
          end else if (RETURN_INSTR && !IDLE_ACTIVE) begin
            state <= ST_RESTORE;
          end
        end
        ST_SAVE: begin
          cyc <= cyc + 2'h1;
          if (cyc == `SAVE_CYC - 2'h1) begin
            state <= ST_BRANCH;
          end
        end
        ST_BRANCH: begin
          state <= ST_RUN;
        end
        ST_RESTORE: begin
          cyc <= cyc + 2'h1;
          if (cyc == `RESTORE_CYC - 2'h1) begin
            state <= ST_RUN;
          end
        end
      endcase
    end
  end
  // Stack and branch strobes registered so they align with state
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      STATE_PUSH <= 1'b0;
      STATE_POP <= 1'b0;
      VEC_BRANCH <= 1'b0;
      RESUME <= 1'b0;
    end else begin
      STATE_PUSH <= (state == ST_RUN && (take_b || take_a || take_irq)) ||
                    (state == ST_SAVE && cyc != `SAVE_CYC - 2'h1);
      STATE_POP <= (state == ST_RUN && !take_b && !take_a && !take_irq && RETURN_INSTR && !IDLE_ACTIVE) ||
                   (state == ST_RESTORE && cyc != `RESTORE_CYC - 2'h1);
      VEC_BRANCH <= (state == ST_SAVE && cyc == `SAVE_CYC - 2'h1);
      RESUME <= (state == ST_RESTORE && cyc == `RESTORE_CYC - 2'h1);
    end
  end
  // ---------------------------------------------
  // Data address formation
  // ---------------------------------------------
  // page pointer plus 14-bit offset
  assign page_sel = DPP_PAGES[DPP_SEL*`PAGE_W +: `PAGE_W];
  always_comb begin
    next_addr = {page_sel, OPER_ADDR[`OFFS_W-1:0]};
    if (ext.seg_ovr) begin
      next_addr = {ext.seg, OPER_ADDR};
    end else if (ext.page_ovr) begin
      next_addr = {ext.page, OPER_ADDR[`OFFS_W-1:0]};
    end
  end
  // Registered address and redirect keep outputs glitch free
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      DATA_ADDR <= '0;
      SHORT_TO_EXTENDED_SFR_SPACE <= 1'b0;
    end else begin
      DATA_ADDR <= next_addr;
      // short modes go to extended space
      SHORT_TO_EXTENDED_SFR_SPACE <= SHORT_ACCESS && ext.extended_sfr_space;
    end
  end
  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  no_irq_locked_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    LOCKED |-> !IRQ_ACK && !TRAP_A_ACK && !PET_GRANT)
    else $error("service during locked run");
  b_breaks_run_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    TRAP_B_ACK |=> !LOCKED)
    else $error("class B trap did not break run");
  lock_immediate_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (loading && !TRAP_B_ACK) |-> !IRQ_ACK && !TRAP_A_ACK && !PET_GRANT ##1 LOCKED)
    else $error("inhibit not immediate");
  b_pending_nolock_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CLASS_B_PENDING && !LOCKED) |=> !LOCKED)
    else $error("lock took effect with class B pending");
  prio_gate_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    IRQ_ACK |-> IRQ_PRIO > CPU_PRIO)
    else $error("low priority interrupt taken");
  entry_seq_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (IRQ_ACK || TRAP_A_ACK || TRAP_B_ACK) |=> STATE_PUSH ##1 STATE_PUSH ##1 VEC_BRANCH)
    else $error("entry sequence wrong");
  return_seq_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (state == ST_RUN && RETURN_INSTR && !IDLE_ACTIVE && !take_b && !take_a && !take_irq)
      |=> STATE_POP ##1 STATE_POP ##1 RESUME)
    else $error("return sequence wrong");
  seg_addr_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    ext.seg_ovr |=> DATA_ADDR == {$past(ext.seg), $past(OPER_ADDR)})
    else $error("segment address wrong");
  extended_sfr_space_redir_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (SHORT_ACCESS && ext.extended_sfr_space) |=> SHORT_TO_EXTENDED_SFR_SPACE)
    else $error("short access not redirected");
  // Redirect ends with the run
  extended_sfr_space_off_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    !ext.extended_sfr_space |=> !SHORT_TO_EXTENDED_SFR_SPACE)
    else $error("short access redirected outside a run");
  // Long accesses never redirected
  extended_sfr_space_short_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    !SHORT_ACCESS |=> !SHORT_TO_EXTENDED_SFR_SPACE)
    else $error("long access redirected");
  // ---------------------------------------------
  // Address checks
  // ---------------------------------------------
  // Page override keeps the 14-bit offset
  page_addr_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (ext.page_ovr && !ext.seg_ovr) |=> DATA_ADDR == {$past(ext.page), $past(OPER_ADDR[`OFFS_W-1:0])})
    else $error("page override address wrong");
  // Normal scheme picks the selected pointer
  dpp_addr_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (!ext.page_ovr && !ext.seg_ovr) |=>
      DATA_ADDR == {$past(DPP_PAGES[DPP_SEL*`PAGE_W +: `PAGE_W]), $past(OPER_ADDR[`OFFS_W-1:0])})
    else $error("page pointer address wrong");
  // Overrides only live inside a run
  ovr_in_run_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (ext.page_ovr || ext.seg_ovr || ext.extended_sfr_space) |-> LOCKED)
    else $error("override outside a run");
  // Class B pending leaves the override flags alone
  b_pending_noovr_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CLASS_B_PENDING && !ext.page_ovr && !ext.seg_ovr && !ext.extended_sfr_space)
      |=> !ext.page_ovr && !ext.seg_ovr && !ext.extended_sfr_space)
    else $error("override took effect with class B pending");
  // ---------------------------------------------
  // Service checks
  // ---------------------------------------------
  // Class B is taken even inside a run
  b_in_run_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (LOCKED && CLASS_B_REQ && state == ST_RUN) |-> TRAP_B_ACK)
    else $error("class B trap held off by run");
  // Class A taken when free, whatever the priority
  trap_a_free_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (state == ST_RUN && CLASS_A_REQ && !CLASS_B_REQ && !LOCKED && !loading) |-> TRAP_A_ACK)
    else $error("class A trap not taken");
  // Held interrupt served as soon as the run ends
  irq_after_run_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    ($fell(LOCKED) && state == ST_RUN && IRQ_REQ && IRQ_PRIO > CPU_PRIO &&
     !CLASS_B_REQ && !CLASS_A_REQ && !loading) |-> IRQ_ACK)
    else $error("held interrupt not served after run");
  // Held event transfer served as soon as the run ends
  pet_after_run_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    ($fell(LOCKED) && state == ST_RUN && PET_REQ && !CLASS_B_REQ && !CLASS_A_REQ &&
     !take_irq && !loading) |-> PET_GRANT)
    else $error("held event transfer not served after run");
  // Idle in a run keeps event transfers off
  pet_idle_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (LOCKED && IDLE_ACTIVE) |-> !PET_GRANT)
    else $error("event transfer during idle in a run");
  // Only one service granted per cycle
  one_grant_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    $onehot0({TRAP_B_ACK, TRAP_A_ACK, IRQ_ACK, PET_GRANT}))
    else $error("two services granted together");
  // Run never ends without a retire or a class B trap
  retire_only_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (LOCKED && !INSTR_RETIRE && !TRAP_B_ACK) |=> LOCKED)
    else $error("run ended without a retire");
  // Each load starts a run at once unless a class B trap is taken
  load_run_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (loading && !TRAP_B_ACK) |=> LOCKED)
    else $error("load did not start a run");
  // ---------------------------------------------
  // Sequencer checks
  // ---------------------------------------------
  // Nothing granted while sequencing
  hold_no_grant_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    HOLD_FETCH |-> !TRAP_B_ACK && !TRAP_A_ACK && !IRQ_ACK && !PET_GRANT)
    else $error("service granted during entry or return");
  // Vector latched from the granted source
  vec_b_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    TRAP_B_ACK |=> VEC_NUM == $past(CLASS_B_VEC))
    else $error("class B vector wrong");
  vec_a_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    TRAP_A_ACK |=> VEC_NUM == $past(CLASS_A_VEC))
    else $error("class A vector wrong");
  vec_irq_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    IRQ_ACK |=> VEC_NUM == $past(IRQ_VEC))
    else $error("interrupt vector wrong");
  // Stack and branch strobes only while fetch is held
  strobe_held_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (STATE_PUSH || STATE_POP || VEC_BRANCH) |-> HOLD_FETCH)
    else $error("strobe outside a sequence");
  // Fetch released in the resume cycle
  resume_free_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    RESUME |-> !HOLD_FETCH)
    else $error("fetch still held at resume");
  // ---------------------------------------------
  // Run length helper
  // ---------------------------------------------
  // Retires since the last load; catches a counter that never empties
  logic [`CNT_W-1:0] run_seen;
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST || take_b || loading) begin
      run_seen <= `CNT_ZERO;
    end else if (INSTR_RETIRE && LOCKED) begin
      run_seen <= run_seen + `CNT_ONE;
    end
  end
  run_len_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    LOCKED |-> run_seen < `CNT_MAX)
    else $error("locked run longer than four");
endmodule // lock_ctrl

// *** req_model.sv ***
// Request source standing in for the interrupt controller side
`timescale 1ns/1ps
module req_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] raise,
  input wire logic [3:0] ack,
  output logic [3:0] req
);
  // ----------------------------------------
  // Request holding
  // ----------------------------------------
  // Levels stay up until acked; dropping early would hide refusals
  always_ff @(posedge clk) begin
    if (rst) begin
      req <= 4'h0;
    end else begin
      req <= (req | raise) & ~ack;
    end
  end
endmodule // req_model

// *** test_lock_ctrl.sv ***
// Self-checking bench for the locked sequence control block
`timescale 1ns/1ps
`include "lock_ctrl_defs.svh"
module test_lock_ctrl;
  import lock_ctrl_pkg::*;
  logic clk = 0, rst = 1, vld = 0, ret = 0, idle = 0, rti = 0, sacc = 0, bpend = 0;
  ext_op_t op = OP_NONE;
  logic [2:0] cnt = 3'h0;
  logic [9:0] pg = 10'h000;
  logic [7:0] sg = 8'h00, vb = 8'h00, va = 8'h00, vi = 8'h00, vnum;
  logic [1:0] dsel = 2'h0;
  logic [39:0] dpp = 40'h00_0000_0000;
  logic [15:0] oaddr = 16'h0000;
  logic [3:0] raise = 4'h0, irqp = 4'h0, cpup = 4'h0, req;
  logic [23:0] daddr, e;
  logic s2e, locked, push, pop, vbr, resume, hold;
  wire logic [3:0] ack;
  logic [3:0] exp_q[$];
  int n_fail = 0, checks = 0, cyc = 0, sd;

  lock_ctrl i_dut (.CORE_CLK(clk), .SYS_RST(rst), .EXT_OP(op), .EXT_VALID(vld), .EXT_COUNT(cnt),
    .EXT_PAGE(pg), .EXT_SEG(sg), .INSTR_RETIRE(ret), .IDLE_ACTIVE(idle), .RETURN_INSTR(rti),
    .DPP_SEL(dsel), .DPP_PAGES(dpp), .OPER_ADDR(oaddr), .SHORT_ACCESS(sacc), .CLASS_B_PENDING(bpend),
    .CLASS_B_REQ(req[0]), .CLASS_B_VEC(vb), .CLASS_A_REQ(req[1]), .CLASS_A_VEC(va), .IRQ_REQ(req[2]),
    .IRQ_PRIO(irqp), .IRQ_VEC(vi), .PET_REQ(req[3]), .CPU_PRIO(cpup), .DATA_ADDR(daddr),
    .SHORT_TO_EXTENDED_SFR_SPACE(s2e), .LOCKED(locked), .PET_GRANT(ack[3]), .TRAP_B_ACK(ack[0]), .TRAP_A_ACK(ack[1]),
    .IRQ_ACK(ack[2]), .STATE_PUSH(push), .STATE_POP(pop), .VEC_BRANCH(vbr), .VEC_NUM(vnum),
    .RESUME(resume), .HOLD_FETCH(hold));
  req_model i_req (.clk(clk), .rst(rst), .raise(raise), .ack(ack), .req(req));

  // ----------------------------------------
  // Clock, timeout and result checking
  // ----------------------------------------
  initial begin
    forever #20 clk = ~clk;
  end

  // Bounded run so a lost ack cannot hang the bench
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic chk(input string n, input logic [23:0] x, input logic [23:0] s);
    checks++;
    if (s !== x) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", n, x, s);
    end
  endtask

  // Every ack must match the oldest note; an ack with no note is a refusal broken
  always @(negedge clk) begin
    if (!rst && (|ack) === 1'b1) begin
      chk("ack", (exp_q.size() > 0) ? 24'(exp_q.pop_front()) : 24'h00_0000, 24'(ack));
    end
  end

  task automatic wrap_up();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  // Request raised one cycle ahead so it is present in the loading cycle
  task automatic load(input ext_op_t o, input logic [2:0] c, input logic [3:0] r);
    @(posedge clk) raise <= r;
    @(posedge clk) begin
      raise <= 4'h0; op <= o; cnt <= c; pg <= 10'($urandom); sg <= 8'($urandom); vld <= 1'b1;
    end
    @(posedge clk) vld <= 1'b0;
  endtask

  // Random gaps stand for multi-cycle instructions retiring once
  task automatic rt(input int n, input logic [3:0] x);
    repeat (n) begin
      repeat ($urandom_range(2)) @(posedge clk);
      @(posedge clk) ret <= 1'b1;
      @(posedge clk) ret <= 1'b0;
    end
    if (x != 4'h0) exp_q.push_back(x);
  endtask

  // Entry walk from the cycle after the ack
  task automatic entry(input logic [7:0] v);
    @(negedge clk) chk("push", 24'h1, 24'(push));
    chk("vec", 24'(v), 24'(vnum));
    chk("hold", 24'h1, 24'(hold));
    @(negedge clk) chk("push", 24'h1, 24'(push));
    @(negedge clk) chk("branch", 24'h1, 24'(vbr));
    @(negedge clk) chk("hold", 24'h0, 24'(hold));
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    sd = $urandom(32'h023d);
    repeat (6) @(posedge clk);
    rst <= 1'b0; vb <= 8'($urandom); va <= 8'($urandom); vi <= 8'($urandom); irqp <= 4'h5;
    // Lock of three with an interrupt held off, then entry and return
    load(OP_LOCK, 3'h3, 4'h4);
    rt(2, 4'h0);
    @(negedge clk) chk("locked", 24'h1, 24'(locked));
    rt(1, 4'h4);
    @(negedge clk) chk("locked", 24'h0, 24'(locked));
    entry(vi);
    @(posedge clk) rti <= 1'b1;
    @(posedge clk) rti <= 1'b0;
    @(negedge clk) chk("pop", 24'h1, 24'(pop));
    @(negedge clk) chk("pop", 24'h1, 24'(pop));
    @(negedge clk) chk("resume", 24'h1, 24'(resume));
    // Nested reload outlasts the first count
    load(OP_LOCK, 3'h2, 4'h4);
    rt(1, 4'h0);
    load(OP_LOCK, 3'h4, 4'h0);
    rt(3, 4'h0);
    @(negedge clk) chk("locked", 24'h1, 24'(locked));
    rt(1, 4'h4);
    @(negedge clk) entry(vi);
    // Class B breaks a run; class A and interrupt follow in order
    load(OP_LOCK, 3'h4, 4'h6);
    rt(1, 4'h0);
    exp_q.push_back(4'h1);
    exp_q.push_back(4'h2);
    exp_q.push_back(4'h4);
    @(posedge clk) raise <= 4'h1;
    @(posedge clk) raise <= 4'h0;
    @(negedge clk) entry(vb);
    entry(va);
    entry(vi);
    chk("locked", 24'h0, 24'(locked));
    // Pending class B flag disables every lock and extension form
    @(posedge clk) bpend <= 1'b1;
    for (int k = 1; k < 7; k++) begin
      load(ext_op_t'(k), 3'h2, 4'h0);
      @(negedge clk) chk("locked", 24'h0, 24'(locked));
    end
    @(posedge clk) bpend <= 1'b0;
    // Address overrides and register redirect, then the normal scheme again
    for (int k = 2; k < 7; k++) begin
      @(posedge clk) begin
        oaddr <= 16'($urandom); sacc <= 1'b1; dsel <= 2'($urandom); dpp <= 40'({$urandom, $urandom});
      end
      load(ext_op_t'(k), 3'h1, 4'h0);
      @(posedge clk);
      e = (k == 2 || k == 5) ? {pg, oaddr[13:0]} : (k == 3 || k == 6) ? {sg, oaddr} : {dpp[dsel*10+:10], oaddr[13:0]};
      @(negedge clk) chk("addr", e, daddr);
      chk("extended_sfr_space", 24'(k > 3), 24'(s2e));
      chk("locked", 24'h1, 24'(locked));
      rt(1, 4'h0);
      @(posedge clk);
      @(negedge clk) chk("addr", {dpp[dsel*10+:10], oaddr[13:0]}, daddr);
      chk("extended_sfr_space", 24'h0, 24'(s2e));
    end
    // Event transfer held off while idle inside a run
    @(posedge clk) idle <= 1'b1;
    load(OP_LOCK, 3'h2, 4'h8);
    repeat (4) @(posedge clk);
    idle <= 1'b0;
    rt(1, 4'h0);
    rt(1, 4'h8);
    // Operand zero covers one instruction, above four covers four
    load(OP_LOCK, 3'h0, 4'h0);
    rt(1, 4'h0);
    @(negedge clk) chk("locked", 24'h0, 24'(locked));
    load(OP_LOCK, 3'h7, 4'h0);
    rt(3, 4'h0);
    @(negedge clk) chk("locked", 24'h1, 24'(locked));
    rt(1, 4'h0);
    @(negedge clk) chk("locked", 24'h0, 24'(locked));
    // Priority not above the CPU level is refused
    @(posedge clk) begin
      cpup <= 4'h7; irqp <= 4'h7; raise <= 4'h4;
    end
    @(posedge clk) raise <= 4'h0;
    repeat (4) @(posedge clk);
    irqp <= 4'h8;
    exp_q.push_back(4'h4);
    @(negedge clk) entry(vi);
    chk("queue", 24'h0, 24'(exp_q.size()));
    wrap_up();
  end
endmodule // test_lock_ctrl
